// >>> lsv_pkg.sv
package lsv_pkg;

  localparam int LSV_ADDR_W = 8;
  localparam int LSV_DATA_W = 8;
  localparam int LSV_CODE_W = 6;
  localparam int LSV_MV_W = 12;

  // Register offsets.
  localparam logic [7:0] LSV_STBY_OFFSET = 8'h04;
  localparam logic [7:0] LSV_ACT_OFFSET = 8'h05;

  // Field positions in the standby register.
  localparam int LSV_RAMP_EN_BIT = 6;
  localparam int LSV_CODE_MSB = 5;
  localparam int LSV_CODE_LSB = 0;
  localparam int LSV_RSVD_BIT = 7;

  // Voltage decode, in millivolts.
  localparam logic [11:0] LSV_MIN_MV = 12'h258;
  localparam logic [11:0] LSV_MAX_MV = 12'hCE4;
  localparam logic [11:0] LSV_STEP_MV = 12'h032;
  localparam logic [5:0] LSV_CODE_FLOOR = 6'h02;
  localparam logic [5:0] LSV_CODE_CEIL = 6'h38;

  // Reset value of the read data port.
  localparam logic [7:0] LSV_RDATA_RST = 8'h00;

  // Nonvolatile load sequence.
  typedef enum logic [1:0] {
    LSV_ST_LOAD = 2'b00,
    LSV_ST_RUN = 2'b01
  } lsv_state_t;

endpackage

// >>> lsv_decode.sv
`timescale 1ns/1ps
module lsv_decode
  import lsv_pkg::*;
(
  input wire logic [LSV_CODE_W-1:0] i_code,
  output logic [LSV_MV_W-1:0] o_mv
);

  function automatic logic [LSV_MV_W-1:0] code_to_mv(input logic [LSV_CODE_W-1:0] code);
    logic [LSV_MV_W-1:0] steps;
    steps = '0;
    if (code <= LSV_CODE_FLOOR) begin
      code_to_mv = LSV_MIN_MV;
    end else if (code >= LSV_CODE_CEIL) begin
      code_to_mv = LSV_MAX_MV;
    end else begin
      steps = LSV_MV_W'(code - LSV_CODE_FLOOR);
      code_to_mv = LSV_MV_W'(LSV_MIN_MV + LSV_MV_W'(steps * LSV_STEP_MV));
    end
  endfunction

  always_comb begin
    o_mv = code_to_mv(i_code); // [R5]
  end

endmodule

// >>> lsv_regulator_standby_voltage_register.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// Function
// (R1) Bit 6 read/write standby ramp enable.
// (R2) Ramp disabled: keep active voltage in standby.
// (R3) Ramp enabled: standby uses standby code voltage.
// (R4) Bits 5..0 read/write standby voltage code.
// (R5) Code decode: 0.6V floor, 50mV steps, 3.3V cap.
// (R6) Fields load from nonvolatile memory at power-up.
// (R7) Separate active code register at next offset.
// (R8) Bit 7 reads zero, writes ignored.
module lsv_regulator_standby_voltage_register
  import lsv_pkg::*;
#(
  parameter int ADDR_W = LSV_ADDR_W
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [LSV_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_nvm_ramp_en,
  input wire logic [LSV_CODE_W-1:0] i_nvm_stby_code,
  input wire logic [LSV_CODE_W-1:0] i_nvm_act_code,
  input wire logic i_standby,
  output logic [LSV_DATA_W-1:0] o_rdata,
  output logic o_ramp_en,
  output logic [LSV_CODE_W-1:0] o_stby_code,
  output logic [LSV_CODE_W-1:0] o_act_code,
  output logic [LSV_MV_W-1:0] o_target_mv
);

  ////////////////////////////////////////////////////////////////////////////////
  lsv_state_t state_ff;
  logic ramp_en_ff;
  logic [LSV_CODE_W-1:0] stby_code_ff;
  logic [LSV_CODE_W-1:0] act_code_ff;
  logic [LSV_DATA_W-1:0] rdata_ff;
  logic [LSV_MV_W-1:0] target_mv_ff;
  logic [LSV_CODE_W-1:0] sel_code;
  logic [LSV_MV_W-1:0] sel_mv;
  logic [LSV_DATA_W-1:0] nxt_rdata;
  logic wr_stby;
  logic wr_act;

  assign wr_stby = i_wr && (i_addr == ADDR_W'(LSV_STBY_OFFSET));
  assign wr_act = i_wr && (i_addr == ADDR_W'(LSV_ACT_OFFSET));

  ////////////////////////////////////////////////////////////////////////////////
  // The first clock after reset release copies the nonvolatile image in.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_ff <= LSV_ST_LOAD;
    end else begin
      state_ff <= LSV_ST_RUN;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ramp_en_ff <= 1'b0;
      stby_code_ff <= '0;
    end else if (state_ff == LSV_ST_LOAD) begin
      ramp_en_ff <= i_nvm_ramp_en; // [R6]
      stby_code_ff <= i_nvm_stby_code; // [R6]
    end else if (wr_stby) begin
      ramp_en_ff <= i_wdata[LSV_RAMP_EN_BIT]; // [R1]
      stby_code_ff <= i_wdata[LSV_CODE_MSB:LSV_CODE_LSB]; // [R4]
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      act_code_ff <= '0;
    end else if (state_ff == LSV_ST_LOAD) begin
      act_code_ff <= i_nvm_act_code;
    end else if (wr_act) begin
      act_code_ff <= i_wdata[LSV_CODE_MSB:LSV_CODE_LSB]; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        ADDR_W'(LSV_STBY_OFFSET): begin
          nxt_rdata[LSV_RAMP_EN_BIT] = ramp_en_ff;
          nxt_rdata[LSV_CODE_MSB:LSV_CODE_LSB] = stby_code_ff;
          nxt_rdata[LSV_RSVD_BIT] = 1'b0; // [R8]
        end
        ADDR_W'(LSV_ACT_OFFSET): begin
          nxt_rdata[LSV_CODE_MSB:LSV_CODE_LSB] = act_code_ff; // [R7]
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= LSV_RDATA_RST;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // In standby the ramp flag chooses between the two codes.
  assign sel_code = (i_standby && ramp_en_ff) ? stby_code_ff : act_code_ff; // [R2] [R3]

  lsv_decode u_decode (
    .i_code(sel_code),
    .o_mv(sel_mv)
  );

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      target_mv_ff <= LSV_MIN_MV;
    end else begin
      target_mv_ff <= sel_mv; // [R5]
    end
  end

  assign o_rdata = rdata_ff;
  assign o_ramp_en = ramp_en_ff;
  assign o_stby_code = stby_code_ff;
  assign o_act_code = act_code_ff;
  assign o_target_mv = target_mv_ff;

endmodule

// >>> lsv_asserts.sv
`timescale 1ns/1ps
module lsv_asserts import lsv_pkg::*; #(parameter int ADDR_W = LSV_ADDR_W) (
  input wire logic i_core_clk, i_rst_n, i_wr, i_rd, i_standby, i_nvm_ramp_en, o_ramp_en,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire logic [5:0] i_nvm_stby_code, i_nvm_act_code, o_stby_code, o_act_code,
  input wire logic [11:0] o_target_mv
);
  logic run_ff;
  always_ff @(posedge i_core_clk) begin
    run_ff <= i_rst_n;
  end
  function automatic logic [11:0] dec(logic [5:0] c);
    return (c <= 6'h02) ? 12'h258 : (c >= 6'h38) ? 12'hCE4 : 12'h258 + (c - 6'h02) * 12'h032;
  endfunction
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd_std;
    i_rd && i_addr == 8'h04;
  endsequence
  a_rd_std_data: assert property (s_rd_std |=> o_rdata == {1'b0, $past(o_ramp_en), $past(o_stby_code)})
    else $error("standby read data wrong");
  a_rd_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not zero");
  a_wr_std_fields: assert property (run_ff && i_wr && i_addr == 8'h04 |=>
    o_ramp_en == $past(i_wdata[6]) && o_stby_code == $past(i_wdata[5:0])) else $error("standby write lost");
  a_wr_std_keep: assert property (run_ff && !(i_wr && i_addr == 8'h04) |=>
    $stable(o_ramp_en) && $stable(o_stby_code)) else $error("standby fields changed");
  a_wr_act_code: assert property (run_ff && i_wr && i_addr == 8'h05 |=> o_act_code == $past(i_wdata[5:0]))
    else $error("active write lost");
  a_nvm_load: assert property (!run_ff |=> o_ramp_en == $past(i_nvm_ramp_en) &&
    o_stby_code == $past(i_nvm_stby_code) && o_act_code == $past(i_nvm_act_code)) else $error("load wrong");
  a_tgt_ramp: assert property (i_standby && o_ramp_en |=> o_target_mv == dec($past(o_stby_code)))
    else $error("standby target wrong");
  a_tgt_active: assert property (!(i_standby && o_ramp_en) |=> o_target_mv == dec($past(o_act_code)))
    else $error("active target wrong");
endmodule
bind lsv_regulator_standby_voltage_register lsv_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// >>> ldo_standby_voltage_register_test.sv
`timescale 1ns/1ps
module ldo_standby_voltage_register_test;
  import lsv_pkg::*;
  logic i_core_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_standby = 0, i_nvm_ramp_en = 1, o_ramp_en;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [5:0] i_nvm_stby_code = 6'h3F, i_nvm_act_code = 6'h03, o_stby_code, o_act_code;
  logic [11:0] o_target_mv;
  int bad_count = 0, checks_done = 0;
  lsv_regulator_standby_voltage_register uut (.*);
  initial forever #10 i_core_clk = ~i_core_clk;
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge i_core_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", {4'h0, e}, {4'h0, o_rdata});
  endtask
  task automatic tgt(logic [5:0] c);
    logic [11:0] e;
    e = (c < 6'h03) ? 12'h258 : (c >= 6'h38) ? 12'hCE4 : 12'h258 + (c - 6'h02) * 12'h032;
    repeat (2) @(posedge i_core_clk);
    #1 chk("target_mv", e, o_target_mv);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_load();
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1 chk("stby_code", 12'h03F, {6'h00, o_stby_code});
    rd(8'h04, 8'h7F);
  endtask
  task automatic t_decode();
    logic [5:0] codes [8] = '{6'h00, 6'h02, 6'h03, 6'h05, 6'h37, 6'h38, 6'h3F, 6'h19};
    i_standby <= 1'b1;
    foreach (codes[k]) begin
      wr(8'h04, {2'b11, codes[k]});
      tgt(codes[k]);
    end
    rd(8'h04, 8'h59);
  endtask
  task automatic t_hold();
    wr(8'h05, 8'hCA);
    wr(8'h04, 8'h05);
    tgt(6'h0A);
    rd(8'h05, 8'h0A);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    rd(8'h04, 8'h05);
  endtask
  initial begin
    t_load();
    t_decode();
    t_hold();
    tally_and_finish();
  end
  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
endmodule
